// ===== verilog/acr_cfg.svh
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// -----------------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------------
`define ACR_IDX_FEAT      10'h324
`define ACR_IDX_CTL       10'h326
`define ACR_IDX_VEC       10'h328
`define ACR_IDX_MCHDR     10'h330

// -----------------------------------------------------------------------
// fields and values
// -----------------------------------------------------------------------
`define ACR_CTL_SRC       0
`define ACR_CTL_XLAT      1
`define ACR_CTL_REQRD     2
`define ACR_CTL_CPLRD     3
`define ACR_CTL_UPFWD     4
`define ACR_CTL_EGRESS    5
`define ACR_CTL_DIRECT    6
`define ACR_CTL_WMASK     16'h007F
`define ACR_CTL_RST       16'h0000
`define ACR_VEC_RST       16'h0000
`define ACR_FEAT_FLAGS    7'h7F
`define ACR_MASK_SIZE     8'h10
`define ACR_CAP_ID        16'h0012
`define ACR_CAP_VER       4'h1
`define ACR_NXT_RST       12'h000
`define ACR_RESP_OKAY     2'h0
`define ACR_RESP_DECERR   2'h3
`endif

// ===== verilog/acr_pkg.sv
package acr_pkg;
  // write channel progress, one-hot
  typedef enum logic [1:0] {
    acr_w_idle = 2'b01,
    acr_w_resp = 2'b10
  } acr_wstate_t;
endpackage : acr_pkg

// ===== verilog/acr_wmask.sv
`timescale 1ns/1ps
module acr_wmask (
  // port configuration
  input  wire logic [3:0]  port_num,
  input  wire logic        port_merged,
  // writable vector bits
  output logic      [15:0] vec_wmask
);
  // -----------------------------------------------------------------------
  // per-bit writability
  // -----------------------------------------------------------------------
  wire       even_merged = port_merged & ~port_num[0];
  wire [3:0] pair_num    = port_num + 4'h1;
  genvar n;
  generate
    for (n = 0; n < 16; n = n + 1) begin : g_bit
      // own bit, and on an even merged port the partner bit above it, are hardwired zero
      assign vec_wmask[n] = ~(port_num == 4'(n)) &
                            ~(even_merged & (pair_num == 4'(n)));
    end
  endgenerate
endmodule : acr_wmask

// ===== verilog/acr_egress_check.sv
`timescale 1ns/1ps
module acr_egress_check (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // request under inspection
  input  wire logic        req_valid,
  input  wire logic        req_p2p,
  input  wire logic [3:0]  req_target,
  input  wire logic [15:0] block_mask,
  // verdict, one cycle later
  output logic             egress_hit
);
  // -----------------------------------------------------------------------
  // target lookup
  // -----------------------------------------------------------------------
  wire next_hit = req_valid & req_p2p & block_mask[req_target];

  // registered so the verdict meets the forwarding pipe cleanly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      egress_hit <= 1'b0;
    end else if (ce) begin
      egress_hit <= next_hit;
    end
  end
endmodule : acr_egress_check

// ===== verilog/acr_regs.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_regs (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // port configuration, same clock
  input  wire logic [3:0]  port_num,
  input  wire logic        port_downstream,
  input  wire logic        port_merged,
  input  wire logic        nxt_unlock,
  // egress request check
  input  wire logic        req_valid,
  input  wire logic        req_p2p,
  input  wire logic [3:0]  req_target,
  output logic             egress_hit,
  // forwarding enables
  output logic             src_validate_en,
  output logic             xlat_block_en,
  output logic             req_redirect_en,
  output logic             cpl_redirect_en,
  output logic             up_forward_en,
  output logic             egress_ctl_en,
  output logic             direct_xlat_en,
  output logic      [15:0] egress_block_mask
);
  // -----------------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------------
  logic [15:0]         acs_enable_control;
  logic [15:0]         egress_block_vector;
  logic [11:0]         next_pointer;
  acr_pkg::acr_wstate_t wstate;
  logic [9:0]          aw_idx;
  logic                aw_have;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_have;

  // -----------------------------------------------------------------------
  // masks and decode
  // -----------------------------------------------------------------------
  logic [15:0] vec_wmask;

  acr_wmask u_wmask (
    .port_num    (port_num),
    .port_merged (port_merged),
    .vec_wmask   (vec_wmask)
  );

  // byte lanes of the low half-word, and of the next pointer bits 31:20
  wire [15:0] strb16   = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [11:0] strb_hi  = {{8{w_strb[3]}}, {4{w_strb[2]}}};
  // upstream ports keep every enable read-only
  wire [15:0] ctl_wm   = port_downstream ? `ACR_CTL_WMASK : 16'h0000;
  wire [15:0] ctl_m    = ctl_wm & strb16;
  wire [15:0] vec_m    = vec_wmask & strb16;
  wire [11:0] nxt_m    = nxt_unlock ? strb_hi : 12'h000;

  wire do_write  = (wstate == acr_pkg::acr_w_idle) & aw_have & w_have;
  wire wr_feat   = aw_idx == `ACR_IDX_FEAT;
  wire wr_ctl    = aw_idx == `ACR_IDX_CTL;
  wire wr_vec    = aw_idx == `ACR_IDX_VEC;
  wire wr_hdr    = aw_idx == `ACR_IDX_MCHDR;
  wire wr_mapped = wr_feat | wr_ctl | wr_vec | wr_hdr;

  // masked merge: protected bits keep their old value
  wire [15:0] next_ctl = (acs_enable_control & ~ctl_m) |
                         (w_data[15:0] & ctl_m);
  wire [15:0] next_vec = (egress_block_vector & ~vec_m) |
                         (w_data[15:0] & vec_m);
  wire [11:0] next_nxt = (next_pointer & ~nxt_m) |
                         (w_data[31:20] & nxt_m);

  // -----------------------------------------------------------------------
  // read views
  // -----------------------------------------------------------------------
  // masking on read too, so a later port renumbering never exposes stale bits
  wire [15:0] ctl_view = acs_enable_control & `ACR_CTL_WMASK;
  wire [15:0] vec_view = egress_block_vector & vec_wmask;
  wire [31:0] hdr_word = {next_pointer, `ACR_CAP_VER,
                          `ACR_CAP_ID};
  wire [15:0] feat_raw = {`ACR_MASK_SIZE, 1'b0, `ACR_FEAT_FLAGS};
  wire [15:0] feat_word = port_downstream ? feat_raw : 16'h0000;

  wire [9:0] ar_idx    = s_axi_araddr[11:2];
  wire       rd_feat   = ar_idx == `ACR_IDX_FEAT;
  wire       rd_ctl    = ar_idx == `ACR_IDX_CTL;
  wire       rd_vec    = ar_idx == `ACR_IDX_VEC;
  wire       rd_hdr    = ar_idx == `ACR_IDX_MCHDR;
  wire       rd_mapped = rd_feat | rd_ctl | rd_vec | rd_hdr;
  wire [31:0] rd_word  = rd_ctl  ? {16'h0000, ctl_view}  :
                         rd_vec  ? {16'h0000, vec_view}  :
                         rd_feat ? {16'h0000, feat_word} :
                         rd_hdr  ? hdr_word : 32'h0000_0000;

  // -----------------------------------------------------------------------
  // write channels
  // -----------------------------------------------------------------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire b_done  = s_axi_bvalid & s_axi_bready;

  // address and data may arrive in either order; each is held alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx        <= 10'h000;
      aw_have       <= 1'b0;
      s_axi_awready <= 1'b1;
    end else if (ce) begin
      if (aw_take) begin
        aw_idx        <= s_axi_awaddr[11:2];
        aw_have       <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_have       <= 1'b0;
      end else if (b_done) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // write data holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      w_have       <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (ce) begin
      if (w_take) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_have       <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_have       <= 1'b0;
      end else if (b_done) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // response follows both halves; one write outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate       <= acr_pkg::acr_w_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ACR_RESP_OKAY;
    end else if (ce) begin
      case (wstate)
        acr_pkg::acr_w_idle: begin
          if (do_write) begin
            wstate       <= acr_pkg::acr_w_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `ACR_RESP_OKAY : `ACR_RESP_DECERR;
          end
        end
        acr_pkg::acr_w_resp: begin
          if (b_done) begin
            wstate       <= acr_pkg::acr_w_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wstate       <= acr_pkg::acr_w_idle;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // register updates
  // -----------------------------------------------------------------------
  // feature word is constant, so a write to it is accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acs_enable_control  <= `ACR_CTL_RST;
      egress_block_vector <= `ACR_VEC_RST;
      next_pointer        <= `ACR_NXT_RST;
    end else if (ce && do_write) begin
      if (wr_ctl) begin
        acs_enable_control <= next_ctl;
      end
      if (wr_vec) begin
        egress_block_vector <= next_vec;
      end
      if (wr_hdr) begin
        next_pointer <= next_nxt;
      end
    end
  end

  // -----------------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire r_done  = s_axi_rvalid & s_axi_rready;

  // data captured at address acceptance, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ACR_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_mapped ? `ACR_RESP_OKAY : `ACR_RESP_DECERR;
      end else if (r_done) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // forwarding enables
  // -----------------------------------------------------------------------
  // vector is meaningless without the egress enable, so gate it here
  wire [15:0] next_block = ctl_view[`ACR_CTL_EGRESS] ? vec_view :
                           16'h0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_validate_en   <= 1'b0;
      xlat_block_en     <= 1'b0;
      req_redirect_en   <= 1'b0;
      cpl_redirect_en   <= 1'b0;
      up_forward_en     <= 1'b0;
      egress_ctl_en     <= 1'b0;
      direct_xlat_en    <= 1'b0;
      egress_block_mask <= 16'h0000;
    end else if (ce) begin
      src_validate_en   <= ctl_view[`ACR_CTL_SRC];
      xlat_block_en     <= ctl_view[`ACR_CTL_XLAT];
      req_redirect_en   <= ctl_view[`ACR_CTL_REQRD];
      cpl_redirect_en   <= ctl_view[`ACR_CTL_CPLRD];
      up_forward_en     <= ctl_view[`ACR_CTL_UPFWD];
      egress_ctl_en     <= ctl_view[`ACR_CTL_EGRESS];
      direct_xlat_en    <= ctl_view[`ACR_CTL_DIRECT];
      egress_block_mask <= next_block;
    end
  end

  // the check looks at the live mask, one cycle ahead of the output copy
  acr_egress_check u_check (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .req_valid  (req_valid),
    .req_p2p    (req_p2p),
    .req_target (req_target),
    .block_mask (next_block),
    .egress_hit (egress_hit)
  );

  // -----------------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_src_follow;
    ce |=> src_validate_en == $past(ctl_view[`ACR_CTL_SRC]);
  endproperty
  a_src_follow: assert property (p_src_follow)
    else $error("source validation enable does not follow control");
  // the copy only moves on an enabled edge, so ce is asked for there too
  property p_xlat_write;
    ce && do_write && wr_ctl && port_downstream && w_strb[0] ##1 ce
      |=> xlat_block_en == $past(w_data[`ACR_CTL_XLAT], 2);
  endproperty
  a_xlat_write: assert property (p_xlat_write)
    else $error("translation blocking enable missed a write");
  property p_ctl_reserved;
    acs_enable_control[15:7] == 9'h000;
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("reserved control bits not zero");
  property p_upstream_ro;
    ce && do_write && wr_ctl && !port_downstream
      |=> $stable(acs_enable_control);
  endproperty
  a_upstream_ro: assert property (p_upstream_ro)
    else $error("upstream control changed by a write");
  property p_egress_gate;
    ce && !ctl_view[`ACR_CTL_EGRESS] |=> egress_block_mask == 16'h0000;
  endproperty
  a_egress_gate: assert property (p_egress_gate)
    else $error("block mask active without egress enable");
  property p_hit;
    ce && req_valid && req_p2p && next_block[req_target] |=> egress_hit;
  endproperty
  a_hit: assert property (p_hit)
    else $error("blocked target not flagged");
  property p_own_bit;
    vec_view[port_num] == 1'b0;
  endproperty
  a_own_bit: assert property (p_own_bit)
    else $error("own port bit of vector reads one");
  property p_merged;
    port_merged && !port_num[0] |-> vec_view[port_num + 4'h1] == 1'b0;
  endproperty
  a_merged: assert property (p_merged)
    else $error("merged partner bit of vector reads one");
  property p_hdr_const;
    ce && ar_take && rd_hdr |=>
      s_axi_rdata[19:0] == {`ACR_CAP_VER, `ACR_CAP_ID};
  endproperty
  a_hdr_const: assert property (p_hdr_const)
    else $error("multicast header identifier or version wrong");
  property p_nxt_lock;
    ce && !nxt_unlock |=> $stable(next_pointer);
  endproperty
  a_nxt_lock: assert property (p_nxt_lock)
    else $error("next pointer changed while locked");
  property p_mask_size;
    ce && ar_take && rd_feat && port_downstream |=>
      s_axi_rdata[15:8] == `ACR_MASK_SIZE;
  endproperty
  a_mask_size: assert property (p_mask_size)
    else $error("port mask size wrong on downstream port");
  property p_vec_protect;
    ce && do_write && wr_vec |=>
      (egress_block_vector & ~$past(vec_m)) ==
      ($past(egress_block_vector) & ~$past(vec_m));
  endproperty
  a_vec_protect: assert property (p_vec_protect)
    else $error("protected vector bit altered by a write");
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");
  property p_read_answer;
    ce && ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer not raised after address");
endmodule : acr_regs

// ===== testbench/acs_control_and_egress_regs_bench.sv
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acs_control_and_egress_regs_bench;
  // ------------------------------------------------------------------
  // stimulus, observed outputs and model state
  // ------------------------------------------------------------------
  localparam logic [11:0] a_feat = {`ACR_IDX_FEAT, 2'b00};
  localparam logic [11:0] a_ctl  = {`ACR_IDX_CTL, 2'b00};
  localparam logic [11:0] a_vec  = {`ACR_IDX_VEC, 2'b00};
  localparam logic [11:0] a_hdr  = {`ACR_IDX_MCHDR, 2'b00};
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, jit = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata  = 32'h0, s_axi_rdata, last_rd, q;
  logic [3:0]  s_axi_wstrb  = 4'h0, port_num = 4'h0, req_target = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        port_downstream = 1'b1, port_merged = 1'b0, nxt_unlock = 1'b0;
  logic        req_valid = 1'b0, req_p2p = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, egress_hit;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        src_validate_en, xlat_block_en, req_redirect_en;
  logic        cpl_redirect_en, up_forward_en, egress_ctl_en, direct_xlat_en;
  logic [15:0] egress_block_mask, m_ctl, m_vec;
  logic [11:0] m_nxt;
  logic [6:0]  en_w;
  logic [31:0] seed = 32'h6364F4B1, cst = 32'h6364F4B1;
  int          fails = 0, n_checks = 0;
  logic [11:0] tbl [8] = '{a_ctl, a_vec, a_hdr, a_feat, 12'h004, 12'hFFC,
                           a_ctl, a_vec};

  assign en_w = {direct_xlat_en, egress_ctl_en, up_forward_en,
                 cpl_redirect_en, req_redirect_en, xlat_block_en,
                 src_validate_en};

  acr_regs dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .port_num(port_num),
    .port_downstream(port_downstream), .port_merged(port_merged),
    .nxt_unlock(nxt_unlock), .req_valid(req_valid), .req_p2p(req_p2p),
    .req_target(req_target), .egress_hit(egress_hit),
    .src_validate_en(src_validate_en), .xlat_block_en(xlat_block_en),
    .req_redirect_en(req_redirect_en), .cpl_redirect_en(cpl_redirect_en),
    .up_forward_en(up_forward_en), .egress_ctl_en(egress_ctl_en),
    .direct_xlat_en(direct_xlat_en), .egress_block_mask(egress_block_mask)
  );

  // clock; ce stutters only while jit is set, to prove nothing is lost
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cst <= lf(cst);
    ce  <= jit ? cst[3] : 1'b1;
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] lf(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lf

  function automatic logic [31:0] rnd();
    seed = lf(seed);
    return seed;
  endfunction : rnd

  // own bit, and on an even merged port the partner above it, stay clear
  function automatic logic [15:0] vec_wm();
    logic [15:0] m;
    m = 16'hFFFF;
    m[port_num] = 1'b0;
    if (port_merged && !port_num[0]) m[port_num + 4'h1] = 1'b0;
    return m;
  endfunction : vec_wm

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    if (a == a_ctl) return {16'h0000, m_ctl};
    if (a == a_vec) return {16'h0000, m_vec};
    if (a == a_hdr) return {m_nxt, 4'h1, 16'h0012};
    if (a == a_feat && port_downstream) return 32'h0000107F;
    return 32'h00000000;
  endfunction : exp_rd

  function automatic logic [1:0] exp_resp(input logic [11:0] a);
    return (a == a_ctl || a == a_vec || a == a_hdr || a == a_feat) ?
           2'h0 : 2'h3;
  endfunction : exp_resp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // address and data offered together, bready held until the answer
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      // a handshake only counts on an edge where ce let the block see it
      if (s_axi_bvalid && ce && !s_axi_awvalid && !s_axi_wvalid) break;
      if (s_axi_awvalid && s_axi_awready && ce) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready && ce) s_axi_wvalid <= 1'b0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) fails++;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (s_axi_rvalid && ce && !s_axi_arvalid) break;
      if (s_axi_arvalid && s_axi_arready && ce) s_axi_arvalid <= 1'b0;
    end
    d  = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) fails++;
  endtask : axi_read

  // write, update the model, read back
  task automatic do_op(input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
    logic [15:0] bm;
    bm = {{8{s[1]}}, {8{s[0]}}} & ((a == a_ctl) ? 16'h007F : vec_wm());
    axi_write(a, d, s, r);
    check(r, exp_resp(a));
    if (a == a_ctl && port_downstream) m_ctl = (m_ctl & ~bm) | (d[15:0] & bm);
    if (a == a_vec) m_vec = (m_vec & ~bm) | (d[15:0] & bm);
    if (a == a_hdr && nxt_unlock && s[2]) m_nxt[3:0] = d[23:20];
    if (a == a_hdr && nxt_unlock && s[3]) m_nxt[11:4] = d[31:24];
    axi_read(a, last_rd, r);
    check(last_rd, exp_rd(a));
    check(r, exp_resp(a));
  endtask : do_op

  task automatic chk_out();
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    check(en_w[3:0], m_ctl[3:0]);
    check(en_w[6:4], m_ctl[6:4]);
    check(egress_block_mask, m_ctl[5] ? m_vec : 16'h0000);
  endtask : chk_out

  task automatic do_reset(input logic dn, input logic mg);
    logic [31:0] v;
    v = rnd();
    @(posedge aclk);
    aresetn         <= 1'b0;
    port_downstream <= dn;
    port_merged     <= mg;
    port_num        <= mg ? {v[3:1], 1'b0} : v[3:0];
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    m_ctl = 16'h0000;
    m_vec = 16'h0000;
    m_nxt = 12'h000;
  endtask : do_reset

  // ------------------------------------------------------------------
  // main sequence: four reset phases, up/downstream, merged or not
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    for (int ph = 0; ph < 4; ph++) begin
      do_reset(ph % 2 == 0, ph >= 2);
      axi_read(a_ctl, q, r);
      check(q, 32'h0);
      axi_read(a_hdr, q, r);
      check(q[15:0], 16'h0012);
      check(q[19:16], 4'h1);
      check(q[31:20], 12'h000);
      axi_read(a_feat, q, r);
      check(q, port_downstream ? 32'h0000107F : 32'h0);
      chk_out();
      nxt_unlock <= 1'b1;
      do_op(a_ctl, 32'hFFFFFFFF, 4'hF);
      check(last_rd[15:7], 9'h000);
      check(last_rd[6:0], port_downstream ? 7'h7F : 7'h00);
      do_op(a_vec, 32'hFFFFFFFF, 4'hF);
      check(last_rd[15:0], vec_wm());
      check(last_rd[port_num], 1'b0);
      check(last_rd[port_num + 4'h1], !(port_merged && !port_num[0]));
      do_op(a_hdr, 32'hFFFFFFFF, 4'hF);
      check(last_rd[31:20], 12'hFFF);
      nxt_unlock <= 1'b0;
      do_op(a_hdr, 32'h0, 4'hF);
      check(last_rd[31:20], 12'hFFF);
      // random traffic, with ce stuttering for the last few
      for (int i = 0; i < 16; i++) begin
        v = rnd();
        w = rnd();
        nxt_unlock <= v[0];
        jit <= (i >= 12);
        do_op(tbl[v[3:1]], w, v[7:4]);
      end
      jit <= 1'b0;
      chk_out();
      // egress lookups with egress control off, then on where the port is downstream
      for (int e = 0; e < 2; e++) begin
        w = rnd();
        w[5] = e[0];
        do_op(a_ctl, w, 4'hF);
        do_op(a_vec, rnd(), 4'hF);
        for (int i = 0; i < 16; i++) begin
          v = rnd();
          @(posedge aclk);
          req_valid  <= v[0] | v[1];
          req_p2p    <= v[2] | v[3];
          req_target <= v[7:4];
          @(posedge aclk);
          @(negedge aclk);
          check(egress_hit, req_valid & req_p2p & m_ctl[5] & m_vec[req_target]);
        end
        @(posedge aclk);
        req_valid <= 1'b0;
        chk_out();
      end
      $display("phase %0d finished, checks so far %0d", ph, n_checks);
    end
    finish_test();
  end

  // watchdog: the whole run needs a little over a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end
endmodule : acs_control_and_egress_regs_bench
